// file: logic/tdl_pkg.sv
package tdl_pkg;

  // ----------------------------------------------------------------
  // Sizes of the sample and record paths
  // ----------------------------------------------------------------
  localparam int UNITS = 3;
  localparam int CHANS = 12;
  localparam int SW    = 16;
  localparam int REC_W = 432;
  localparam int S0_W  = 272;
  localparam int TAIL_W = 160;

  // ----------------------------------------------------------------
  // Select codes and counts
  // ----------------------------------------------------------------
  localparam logic [6:0] SRC_EXT0    = 7'h15;
  localparam logic [6:0] SRC_EXT1    = 7'h16;
  localparam logic [6:0] SRC_EXT2    = 7'h17;
  localparam logic [7:0] ST_DI_FIRST = 8'h01;
  localparam logic [7:0] ST_DI_LAST  = 8'h0a;
  localparam logic [7:0] ST_DO_FIRST = 8'h0b;
  localparam logic [7:0] ST_DO_LAST  = 8'h14;
  localparam logic [7:0] ST_USER     = 8'h15;
  localparam logic [5:0] STRETCH_CYC = 6'h2a;
  localparam logic [1:0] BUF_DEPTH   = 2'h2;

  // Counter group of one unit as it arrives from the counter logic
  typedef struct packed {
    logic [31:0] count;
    logic        phase_b_in;
    logic        phase_a_in;
  } tdl_quad_s;

  typedef logic [UNITS-1:0][CHANS-1:0][SW-1:0] tdl_samples_t;

  typedef enum logic {TDL_IDLE, TDL_UPPER} tdl_step_e;

endpackage : tdl_pkg

// file: logic/tdl_pipe2.sv
`timescale 1ns/1ps
module tdl_pipe2 #(
  parameter int W = 432
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Two-entry buffer, entry e0 is the head
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]   cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } tdl_pipe_s;

  tdl_pipe_s st_ff;
  tdl_pipe_s nxt_st;

  // Both handshakes are gated by ce so a frozen buffer takes nothing
  assign in_ready  = ce && (st_ff.cnt != tdl_pkg::BUF_DEPTH);
  assign out_valid = ce && (st_ff.cnt != 2'h0);
  assign out_data  = st_ff.e0;

  // Pop shifts the tail forward before a push lands behind it
  always_comb begin
    nxt_st = st_ff;
    if (out_valid && out_ready) begin
      nxt_st.e0  = st_ff.e1;
      nxt_st.cnt = st_ff.cnt - 2'h1;
    end
    if (in_valid && in_ready) begin
      if (nxt_st.cnt == 2'h0) begin
        nxt_st.e0 = in_data;
      end else begin
        nxt_st.e1 = in_data;
      end
      nxt_st.cnt = nxt_st.cnt + 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

endmodule : tdl_pipe2

// file: logic/tdl_log_path.sv
`timescale 1ns/1ps
// Function
// - Sample strobe copies unit's twelve live channels
// - Codes 15h-17h pick unit strobe, else 0
// - Latch sets on selected strobe, clears on pulse
// - Held samples load on latch and pulse
// - Two step pulses follow capture on pulses
// - Half select sets first step, clears second
// - Split active SR-FF stretched 42 cycles
// - Slice zero packs counters or unit-0 samples
// - Slice one picks unit 2 and 1 samples or slice zero plus tail by half
// - Slice two picks full record or slice one
// - Start pick from inputs, outputs or user bit
// - Once mode lets start through only once
// - Auto mode edges follow firmware trigger bit
// - Start codes 01h-15h map bits, else 0
// - Auto mode truth table drives start pick
// - Split mode holds start while split active
module tdl_log_path (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic [2:0]            ext_sample_valid,
  input  wire tdl_pkg::tdl_samples_t live_sample_channel,
  input  wire logic                  log_timing_pulse,
  input  wire logic [6:0]            sample_source_select,
  input  wire logic                  split_mode_select,
  input  wire tdl_pkg::tdl_quad_s [2:0] base_quadrature,
  input  wire tdl_pkg::tdl_quad_s [2:0] ext_quadrature,
  input  wire logic [2:0][15:0]      base_filtered_inputs,
  input  wire logic [2:0][15:0]      ext_filtered_inputs,
  input  wire logic [9:0]            base_driven_outputs,
  input  wire logic [7:0]            start_source_select,
  input  wire logic                  start_once_mode,
  input  wire logic                  start_once_clear,
  input  wire logic                  auto_move_mode,
  input  wire logic                  capture_edge_trigger,
  input  wire logic [1:0]            user_capture_control,
  input  wire logic                  record_ready,
  output logic [431:0]               capture_record,
  output logic                       record_valid,
  output logic                       capture_start_out,
  output logic                       half_select,
  output logic                       split_step_pulse,
  output logic                       split_active
);

  // ----------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    tdl_pkg::tdl_samples_t cap;
    tdl_pkg::tdl_samples_t held;
    logic                  latch;
    tdl_pkg::tdl_step_e    step_st;
    logic                  step;
    logic                  half;
    logic                  div_sr;
    logic [5:0]            stretch;
    logic                  once_done;
    logic                  clr_armed;
    logic                  once_prev;
    logic                  pick;
    logic                  start;
    logic                  push;
    logic [431:0]          rec;
  } tdl_state_s;

  tdl_state_s st_ff;
  tdl_state_s nxt_st;

  logic                       sel_valid;
  logic                       start_bit;
  logic                       once_stage_out;
  logic                       once_rise;
  logic [tdl_pkg::S0_W-1:0]   slice0;
  logic [tdl_pkg::TAIL_W-1:0] rec_tail;
  logic [431:0]               slice1;
  logic [431:0]               rec_mux;
  logic                       buf_in_ready;

  // ----------------------------------------------------------------
  // Sample source and start source decode
  // ----------------------------------------------------------------

  // Only the three extension codes drive the valid line
  always_comb begin
    case (sample_source_select)
      tdl_pkg::SRC_EXT0: sel_valid = ext_sample_valid[0];
      tdl_pkg::SRC_EXT1: sel_valid = ext_sample_valid[1];
      tdl_pkg::SRC_EXT2: sel_valid = ext_sample_valid[2];
      default:           sel_valid = 1'b0;
    endcase
  end

  // Code ranges map straight onto bit indices of the base unit
  always_comb begin
    start_bit = 1'b0;
    if (start_source_select >= tdl_pkg::ST_DI_FIRST &&
        start_source_select <= tdl_pkg::ST_DI_LAST) begin
      start_bit = base_filtered_inputs[0][4'(start_source_select
                  - tdl_pkg::ST_DI_FIRST)];
    end else if (start_source_select >= tdl_pkg::ST_DO_FIRST &&
                 start_source_select <= tdl_pkg::ST_DO_LAST) begin
      start_bit = base_driven_outputs[4'(start_source_select
                  - tdl_pkg::ST_DO_FIRST)];
    end else if (start_source_select == tdl_pkg::ST_USER) begin
      start_bit = user_capture_control[0];
    end
  end

  // Once stage blocks the start after its first high phase
  assign once_stage_out = start_once_mode ?
                          (start_bit && !st_ff.once_done) :
                          start_bit;
  assign once_rise = once_stage_out && !st_ff.once_prev;

  // ----------------------------------------------------------------
  // Record slices
  // ----------------------------------------------------------------

  // Low tail shared by the full record and the upper half
  assign rec_tail = {14'h0, base_quadrature[1].phase_b_in,
                     base_quadrature[1].phase_a_in,
                     base_quadrature[0].count, 14'h0,
                     base_quadrature[0].phase_b_in,
                     base_quadrature[0].phase_a_in,
                     ext_filtered_inputs[2], ext_filtered_inputs[1],
                     ext_filtered_inputs[0], base_filtered_inputs[2],
                     base_filtered_inputs[1], base_filtered_inputs[0]};

  // Slice zero, counters in full mode, unit-0 samples when split
  always_comb begin
    if (split_mode_select) begin
      slice0 = {80'h0, st_ff.held[0]};
    end else begin
      slice0 = {48'h0,
                ext_quadrature[2].count, 14'h0,
                ext_quadrature[2].phase_b_in,
                ext_quadrature[2].phase_a_in,
                ext_quadrature[1].count, 14'h0,
                ext_quadrature[1].phase_b_in,
                ext_quadrature[1].phase_a_in,
                ext_quadrature[0].count, 14'h0,
                ext_quadrature[0].phase_b_in,
                ext_quadrature[0].phase_a_in,
                base_quadrature[2].count, 14'h0,
                base_quadrature[2].phase_b_in,
                base_quadrature[2].phase_a_in,
                base_quadrature[1].count};
    end
  end

  // Lower half carries units 2 and 1, upper half the rest
  assign slice1 = st_ff.half ? {slice0, rec_tail} :
                  {48'h0, st_ff.held[2], st_ff.held[1]};
  assign rec_mux = split_mode_select ? slice1 :
                   {slice0, rec_tail};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Each unit's strobe refreshes its own capture set
    for (int u = 0; u < tdl_pkg::UNITS; u++) begin
      if (ext_sample_valid[u]) begin
        nxt_st.cap[u] = live_sample_channel[u];
      end
    end

    // Held set moves only on latch with timing pulse
    if (st_ff.latch && log_timing_pulse) begin
      nxt_st.held = st_ff.cap;
    end

    // Strobe wins over the clearing pulse
    if (sel_valid) begin
      nxt_st.latch = 1'b1;
    end else if (log_timing_pulse) begin
      nxt_st.latch = 1'b0;
    end

    // Step sequencer: first pulse after capture, then the next
    nxt_st.step = 1'b0;
    case (st_ff.step_st)
      tdl_pkg::TDL_IDLE: begin
        if (st_ff.latch && log_timing_pulse) begin
          nxt_st.step    = 1'b1;
          nxt_st.half    = 1'b1;
          nxt_st.div_sr  = 1'b1;
          nxt_st.step_st = tdl_pkg::TDL_UPPER;
        end
      end
      tdl_pkg::TDL_UPPER: begin
        if (log_timing_pulse) begin
          nxt_st.step    = 1'b1;
          nxt_st.half    = 1'b0;
          nxt_st.div_sr  = 1'b0;
          nxt_st.step_st = tdl_pkg::TDL_IDLE;
        end
      end
      default: nxt_st.step_st = tdl_pkg::TDL_IDLE;
    endcase

    // Stretch keeps split active 42 cycles past the SR reset
    if (st_ff.div_sr && !nxt_st.div_sr) begin
      nxt_st.stretch = tdl_pkg::STRETCH_CYC;
    end else if (st_ff.stretch != 6'h0) begin
      nxt_st.stretch = st_ff.stretch - 6'h1;
    end

    // Rearm needs a full 0,1,0 on the clear bit
    if (start_once_clear) begin
      nxt_st.clr_armed = 1'b1;
    end else if (st_ff.clr_armed) begin
      nxt_st.clr_armed = 1'b0;
      nxt_st.once_done = 1'b0;
    end
    // A falling start marks the single shot as spent; set wins
    if (start_once_mode && st_ff.once_prev && !once_stage_out) begin
      nxt_st.once_done = 1'b1;
    end
    nxt_st.once_prev = once_stage_out;

    // Through output, or firmware-steered edges in auto mode
    if (!auto_move_mode) begin
      nxt_st.pick = once_stage_out;
    end else if (!capture_edge_trigger && !once_stage_out) begin
      nxt_st.pick = 1'b0;
    end else if (capture_edge_trigger && once_rise) begin
      nxt_st.pick = 1'b1;
    end

    // Start output freezes during a split record pair
    if (!(split_mode_select && split_active)) begin
      nxt_st.start = st_ff.pick;
    end

    // A stalled push holds the record so no word is lost
    if (!(st_ff.push && !buf_in_ready)) begin
      nxt_st.push = split_mode_select ? st_ff.step :
                    log_timing_pulse;
      nxt_st.rec  = rec_mux;
    end
  end

  // ----------------------------------------------------------------
  // State register and output buffer
  // ----------------------------------------------------------------

  // Single clock, sync reset to zero, ce freezes everything
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign half_select       = st_ff.half;
  assign split_step_pulse  = st_ff.step;
  assign split_active      = st_ff.div_sr || (st_ff.stretch != 6'h0);
  assign capture_start_out = st_ff.start;

  // Two entries absorb a receiver stall without dropping a record
  tdl_pipe2 #(
    .W (tdl_pkg::REC_W)
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (st_ff.push),
    .in_ready  (buf_in_ready),
    .in_data   (st_ff.rec),
    .out_valid (record_valid),
    .out_ready (record_ready),
    .out_data  (capture_record)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_first_step;
    ce && st_ff.step && st_ff.half;
  endsequence

  sequence s_second_wait;
    ce && st_ff.step_st == tdl_pkg::TDL_UPPER && log_timing_pulse;
  endsequence

  a_capture_copy: assert property (
    ce && ext_sample_valid[0] |=>
    st_ff.cap[0] == $past(live_sample_channel[0]))
    else $error("unit 0 capture missed");

  a_source_decode: assert property (
    sel_valid == ((sample_source_select == 7'h15 &&
                   ext_sample_valid[0]) ||
                  (sample_source_select == 7'h16 &&
                   ext_sample_valid[1]) ||
                  (sample_source_select == 7'h17 &&
                   ext_sample_valid[2])))
    else $error("sample source decode wrong");

  a_latch_clear: assert property (
    ce && !sel_valid && log_timing_pulse |=> !st_ff.latch)
    else $error("latch not cleared by pulse");

  a_held_keep: assert property (
    ce && !(st_ff.latch && log_timing_pulse) |=>
    $stable(st_ff.held))
    else $error("held samples changed");

  a_half_upper: assert property (
    s_first_step |-> split_active && st_ff.step_st ==
    tdl_pkg::TDL_UPPER)
    else $error("first step did not arm upper");

  a_second_step: assert property (
    s_second_wait |=> st_ff.step && !st_ff.half && !st_ff.div_sr)
    else $error("second step missing");

  a_stretch_hold: assert property (
    ce && $fell(st_ff.div_sr) |-> split_active &&
    st_ff.stretch == tdl_pkg::STRETCH_CYC)
    else $error("split active not stretched");

  a_tail_words: assert property (
    !split_mode_select |-> rec_mux[15:0] ==
    base_filtered_inputs[0] && rec_mux[431:384] == 48'h0)
    else $error("full record layout wrong");

  a_start_user: assert property (
    start_source_select == 8'h15 |->
    start_bit == user_capture_control[0])
    else $error("user start bit not picked");

  a_start_hold: assert property (
    ce && split_mode_select && split_active |=>
    $stable(capture_start_out))
    else $error("start moved while split active");

endmodule : tdl_log_path

// file: testbench/tdl_log_sink.sv
`timescale 1ns/1ps
module tdl_log_sink (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         stall,
  input  wire logic         slow,
  input  wire logic         record_valid,
  input  wire logic [431:0] capture_record,
  output logic              record_ready
);
  // ----------------------------------------------------------------
  // Record receiver
  // ----------------------------------------------------------------
  logic [431:0] recs[$];
  logic         tick_ff;

  // Slow mode takes a word only every other cycle, so the buffer backs up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_ff <= 1'h0;
    end else begin
      tick_ff <= ~tick_ff;
      if (record_valid && record_ready) begin
        recs.push_back(capture_record);
      end
    end
  end

  // Stall wins over everything; the bench drives it only at clock edges
  assign record_ready = ~stall & (~slow | tick_ff);
endmodule : tdl_log_sink

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic                     clk, sys_rst, ce, ltp, split_mode, once, clr;
  logic                     auto_m, trig, stall, slow;
  logic                     rdy, rv, cso, hs, ssp, sa;
  logic [2:0]               esv;
  logic [6:0]               ssel;
  logic [7:0]               stsel;
  logic [9:0]               bdo;
  logic [1:0]               ucc;
  logic [2:0][15:0]         bfi, efi;
  logic [431:0]             rec;
  logic [271:0]             e0;
  logic [30:0]              rows[11];
  tdl_pkg::tdl_samples_t    live, smp;
  tdl_pkg::tdl_quad_s [2:0] bq, eq;
  int                       miscompares, compares, cyc, n;

  tdl_log_path DUT (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .ce                   (ce),
    .ext_sample_valid     (esv),
    .live_sample_channel  (live),
    .log_timing_pulse     (ltp),
    .sample_source_select (ssel),
    .split_mode_select    (split_mode),
    .base_quadrature      (bq),
    .ext_quadrature       (eq),
    .base_filtered_inputs (bfi),
    .ext_filtered_inputs  (efi),
    .base_driven_outputs  (bdo),
    .start_source_select  (stsel),
    .start_once_mode      (once),
    .start_once_clear     (clr),
    .auto_move_mode       (auto_m),
    .capture_edge_trigger (trig),
    .user_capture_control (ucc),
    .record_ready         (rdy),
    .capture_record       (rec),
    .record_valid         (rv),
    .capture_start_out    (cso),
    .half_select          (hs),
    .split_step_pulse     (ssp),
    .split_active         (sa)
  );

  tdl_log_sink PART (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .stall          (stall),
    .slow           (slow),
    .record_valid   (rv),
    .capture_record (rec),
    .record_ready   (rdy)
  );

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [431:0] e, logic [431:0] s);
    compares++;
    if (e !== s) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic pulse();
    @(posedge clk);
    ltp <= 1'h1;
    @(posedge clk);
    ltp <= 1'h0;
    #1;
  endtask : pulse

  // Live values flip after the strobe, so a late capture shows up
  task automatic sp(logic [2:0] s, logic e);
    @(posedge clk);
    esv <= s;
    @(posedge clk);
    esv <= 3'h0;
    live <= ~live;
    pulse();
    chk("step", e, ssp);
  endtask : sp

  task automatic st(logic [1:0] u, logic e);
    @(posedge clk);
    ucc <= u;
    repeat (4) @(posedge clk);
    #1;
    chk("start", e, cso);
  endtask : st

  function automatic logic [47:0] q(tdl_pkg::tdl_quad_s x);
    return {x.count, 14'h0, x.phase_b_in, x.phase_a_in};
  endfunction : q

  // Low 160 bits that every full record and upper half carry
  function automatic logic [159:0] tl();
    return {14'h0, bq[1].phase_b_in, bq[1].phase_a_in, q(bq[0]), efi, bfi};
  endfunction : tl

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {ce, sys_rst} = 2'h3;
    {ltp, split_mode, once, clr, auto_m, trig, stall, slow} = 8'h0;
    {esv, ssel, stsel, bdo, ucc, bfi, cyc} = '0;
    {miscompares, compares} = '0;
    efi = {16'h0e02, 16'h0e01, 16'h0e00};
    bfi[2:1] = {16'h0b02, 16'h0b01};
    for (int u = 0; u < 3; u++) begin
      bq[u] = {32'(32'ha000 + u), 2'(u + 1)};
      eq[u] = {32'(32'hb000 + u), 2'(3 - u)};
      for (int c = 0; c < 12; c++) begin
        smp[u][c] = 16'(16'h1000 * (u + 1) + c);
      end
    end
    live = smp;
    // Code, filtered bits, driven bits, user bits, expected start
    rows = '{{8'h01, 10'h001, 10'h000, 2'h0, 1'h1},
             {8'h01, 10'h3fe, 10'h3ff, 2'h3, 1'h0},
             {8'h0a, 10'h200, 10'h000, 2'h0, 1'h1},
             {8'h0a, 10'h1ff, 10'h3ff, 2'h3, 1'h0},
             {8'h0b, 10'h000, 10'h001, 2'h0, 1'h1},
             {8'h0b, 10'h3ff, 10'h3fe, 2'h3, 1'h0},
             {8'h14, 10'h000, 10'h200, 2'h0, 1'h1},
             {8'h15, 10'h000, 10'h000, 2'h1, 1'h1},
             {8'h15, 10'h3ff, 10'h3ff, 2'h2, 1'h0},
             {8'h16, 10'h3ff, 10'h3ff, 2'h3, 1'h0},
             {8'h00, 10'h3ff, 10'h3ff, 2'h3, 1'h0}};
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    chk("idle", 5'h0, {cso, rv, hs, ssp, sa});
    foreach (rows[i]) begin
      @(posedge clk);
      stsel <= rows[i][30:23];
      bfi[0][9:0] <= rows[i][22:13];
      bdo <= rows[i][12:3];
      st(rows[i][2:1], rows[i][0]);
    end
    @(posedge clk);
    stsel <= 8'h15;
    ucc <= 2'h0;
    once <= 1'h1;
    st(2'h1, 1'h1);
    st(2'h0, 1'h0);
    st(2'h1, 1'h0);
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    st(2'h0, 1'h0);
    st(2'h1, 1'h1);
    @(posedge clk);
    once <= 1'h0;
    auto_m <= 1'h1;
    st(2'h0, 1'h0);
    @(posedge clk);
    trig <= 1'h1;
    st(2'h1, 1'h1);
    st(2'h0, 1'h1);
    @(posedge clk);
    trig <= 1'h0;
    st(2'h1, 1'h0);
    // Split records: upper half then lower half from one capture
    @(posedge clk);
    auto_m <= 1'h0;
    split_mode <= 1'h1;
    slow <= 1'h1;
    ssel <= 7'h15;
    repeat (5) @(posedge clk);
    sp(3'h7, 1'h1);
    chk("half", 1'h1, hs);
    chk("active", 1'h1, sa);
    @(posedge clk);
    ucc <= 2'h0;
    #1;
    chk("step", 1'h0, ssp);
    pulse();
    chk("step", 1'h1, ssp);
    chk("half", 1'h0, hs);
    n = 0;
    while (sa === 1'h1 && n < 100) begin
      n++;
      if (n == 20) begin
        chk("hold", 1'h1, cso);
      end
      @(posedge clk);
      #1;
    end
    chk("stretch", 42, n);
    repeat (3) @(posedge clk);
    #1;
    chk("start", 1'h0, cso);
    pulse();
    chk("step", 1'h0, ssp);
    chk("count", 2, PART.recs.size());
    chk("upper", {80'h0, smp[0]}, PART.recs[0][431:160]);
    chk("lower", {48'h0, smp[2], smp[1]}, PART.recs[1]);
    chk("utail", tl(), PART.recs[0][159:0]);
    // Only the selected unit's strobe arms a step
    for (int u = 0; u < 3; u++) begin
      @(posedge clk);
      ssel <= 7'(7'h15 + u);
      sp(3'(1 << ((u + 1) % 3)), 1'h0);
      sp(3'(1 << u), 1'h1);
      pulse();
      chk("step", 1'h1, ssp);
    end
    @(posedge clk);
    ssel <= 7'h18;
    sp(3'h7, 1'h0);
    // Receiver stalls across three whole records; none may be lost
    @(posedge clk);
    split_mode <= 1'h0;
    slow <= 1'h0;
    repeat (10) @(posedge clk);
    stall <= 1'h1;
    n = PART.recs.size();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      bq[1].count <= 32'h100 + k;
      pulse();
      repeat (2) @(posedge clk);
    end
    #1;
    e0 = {48'h0, q(eq[2]), q(eq[1]), q(eq[0]), q(bq[2]), bq[1].count};
    chk("valid", 1'h1, rv);
    @(posedge clk);
    stall <= 1'h0;
    repeat (12) @(posedge clk);
    #1;
    chk("count", n + 3, PART.recs.size());
    chk("empty", 1'h0, rv);
    for (int k = 0; k < 3; k++) begin
      chk("full", {e0[271:32], 32'(32'h100 + k)},
          PART.recs[n + k][431:160]);
      chk("tail", tl(), PART.recs[n + k][159:0]);
    end
    // Frozen block ignores a pulse and pushes no record
    @(posedge clk);
    ce <= 1'h0;
    pulse();
    @(posedge clk);
    ce <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    chk("frozen", n + 3, PART.recs.size());
    results();
  end
endmodule : tb_top
